// file: rtl/pss_sequencer.sv
// Functional notes
// - straps sampled at power-up and restore only
// - enable active high, floating reads high
// - all settings but address, sync and ceiling are bus writable
// - commanded vout clamped to 110% strap
// - factory load ignores enable and bus writes
// - load factory, strap, default, user, then ready
// - default layer sets all entries but vout; vout keeps strap value
// - user layer overrides both except ceiling
// - restore commands rerun layers; factory restarts all
// - fixed pre-ramp delay plus configured delay
// - ramp to target over soft-start time
// - ramp starts from pre-biased output voltage
// - flag error if pre-bias above overvoltage
// - power good only in tolerance, no fault
// - power good delay defaults to ramp time
// - tolerance, polarity and delay are configurable
// - stop delay then soft-stop ramp to ground
// - delay after ground then output high impedance
// - optional early high impedance below threshold
// - three-level strap selects 0.6/1.2/2.5 V
// - resistor strap decoded through 28-entry table
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module pss_sequencer
    import pss_pkg::*;
#(
    parameter int FACT_CYCLES = FACT_CYC,
    parameter int PRE_CYCLES = PRE_CYC,
    parameter int HIZ_CYCLES = HIZ_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // enable pin and its floating detect
    input wire logic module_en_in,
    input wire logic module_en_float,
    // strap pins
    input wire logic [2:0] addr_strap_lo,
    input wire logic [2:0] addr_strap_hi,
    input wire logic sync_strap,
    input wire logic [1:0] vout_strap_pin,
    input wire logic [4:0] vout_strap_res,
    // measured output voltage
    input wire logic [11:0] vout_sense_mv,
    // converter control and status
    output logic [11:0] vout_set_mv,
    output logic stage_drive,
    output logic power_good_out,
    output logic fault_flag,
    output logic [5:0] smbus_addr,
    output logic sync_sel
);

    ////////////////////////////////////////////////////////////////////////
    // state
    pss_state_t st_reg;
    pss_state_t st_next;
    logic [31:0] tmr_reg;
    logic [15:0] cfg_reg [NCFG];
    logic [15:0] cfg_next [NCFG];
    logic [15:0] user_reg [NCFG];
    logic user_ok_reg;
    logic [11:0] vmax_reg;
    logic [5:0] addr_reg;
    logic sync_reg;
    logic [11:0] sp_reg;
    logic [11:0] sp_next;
    logic [31:0] acc_reg;
    logic [31:0] acc_next;
    logic [11:0] diff_reg;
    logic [11:0] diff_next;
    logic up_reg;
    logic up_next;
    logic drive_reg;
    logic err_reg;
    logic [31:0] pgc_reg;
    logic pg_raw_reg;
    logic pg_out_reg;
    logic dph_wr_reg;
    logic dph_map_reg;
    logic [7:0] dph_a_reg;
    logic [31:0] rdata_reg;
    logic ready_reg;

    ////////////////////////////////////////////////////////////////////////
    // enable pin: a floating pin reads high, as the internal pull-up does
    wire en_eff = module_en_in | module_en_float;
    wire st_fact = (st_reg == S_FACT);
    wire [31:0] t1 = tmr_reg + 32'h1;
    wire [31:0] tick32 = 32'(TICK_CYC);

    ////////////////////////////////////////////////////////////////////////
    // ahb address phase and data phase decode
    wire aph = hsel & hready & htrans[1];
    wire hi_zero = (haddr[31:8] == 24'h0);
    // bus writes are dropped while factory settings load
    wire wr_en = dph_wr_reg & dph_map_reg & ~st_fact;
    wire wr_rst = wr_en & (dph_a_reg == A_RESTORE);
    wire wr_stat = wr_en & (dph_a_reg == A_STATUS);
    wire rst_fact = wr_rst & hwdata[R_FACT_BIT];
    wire rst_dflt = wr_rst & hwdata[R_DFLT_BIT];
    wire rst_user = wr_rst & hwdata[R_USER_BIT];
    wire store_user = wr_rst & hwdata[R_STORE_BIT];

    // layer load strobes, from the sequence or from a restore
    wire strap_smp = (st_reg == S_STRAP) | rst_dflt | rst_user;
    wire ld_dflt = (st_reg == S_DFLT) | rst_dflt;
    wire ld_user = ((st_reg == S_USER) | rst_user) & user_ok_reg;

    ////////////////////////////////////////////////////////////////////////
    // strap decode: three levels, or resistor table when level is 3
    wire [4:0] res_idx = (vout_strap_res < 5'(NRES)) ? vout_strap_res
                       : 5'(NRES - 1);
    wire [11:0] lvl_mv = (vout_strap_pin == LVL_LO) ? MV_LO
                       : (vout_strap_pin == LVL_OPEN) ? MV_OPEN : MV_HI;
    wire res_mode = (vout_strap_pin != LVL_LO) & (vout_strap_pin != LVL_OPEN)
                  & (vout_strap_pin != LVL_HI);
    wire [11:0] strap_mv = res_mode ? RES_MV[res_idx] : lvl_mv;
    wire [15:0] vm_mul = {4'h0, strap_mv} * VMAX_NUM;
    wire [15:0] vm_quo = vm_mul / VMAX_DEN;
    wire [11:0] vmax_cur = strap_smp ? vm_quo[11:0] : vmax_reg;

    // clamp any voltage to the strap ceiling
    function automatic logic [15:0] clamp_mv(input logic [15:0] v,
                                             input logic [11:0] m);
        clamp_mv = (v > {4'h0, m}) ? {4'h0, m} : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration entries: user beats default beats strap beats bus
    genvar gi;
    generate
        for (gi = 0; gi < NCFG; gi++) begin : g_cfg
            wire hit = wr_en & (dph_a_reg == 8'(A_CFG0 + 4 * gi));
            wire [15:0] wval = (gi == C_VOUT) ? clamp_mv(hwdata[15:0], vmax_cur)
                             : hwdata[15:0];
            wire [15:0] uval = (gi == C_VOUT) ? clamp_mv(user_reg[gi], vmax_cur)
                             : user_reg[gi];
            // the voltage entry has no default, so the strap value survives
            assign cfg_next[gi] = ld_user ? uval
                : (ld_dflt && gi != C_VOUT) ? DFLT_CFG[gi]
                : (strap_smp && gi == C_VOUT) ? {4'h0, strap_mv}
                : hit ? wval : cfg_reg[gi];

            // entry register and its user copy
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    cfg_reg[gi] <= DFLT_CFG[gi];
                    user_reg[gi] <= DFLT_CFG[gi];
                end else begin
                    cfg_reg[gi] <= cfg_next[gi];
                    if (store_user)
                        user_reg[gi] <= cfg_reg[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // strap latches; the ceiling changes only when straps are sampled, including on default and user restores
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vmax_reg <= 12'h0;
            addr_reg <= 6'h0;
            sync_reg <= 1'b0;
            user_ok_reg <= 1'b0;
        end else begin
            if (strap_smp) begin
                vmax_reg <= vm_quo[11:0];
                addr_reg <= {addr_strap_hi, addr_strap_lo};
                sync_reg <= sync_strap;
            end
            if (store_user)
                user_ok_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // delay and ramp lengths in cycles
    wire [31:0] pre_tot = 32'(PRE_CYCLES) + {16'h0, cfg_reg[C_ONDLY]} * tick32;
    wire [31:0] off_tot = {16'h0, cfg_reg[C_OFFDLY]} * tick32;
    wire [31:0] rise_tot = {16'h0, cfg_reg[C_RISE]} * tick32;
    wire [31:0] fall_tot = {16'h0, cfg_reg[C_FALL]} * tick32;
    wire ramp_st = (st_reg == S_UP) | (st_reg == S_DN);
    wire [31:0] ramp_tot = (st_reg == S_UP) ? rise_tot : fall_tot;
    wire ramp_end = (t1 >= ramp_tot);
    wire [11:0] vtgt = cfg_reg[C_VOUT][11:0];
    wire [11:0] ramp_tgt = (st_reg == S_UP) ? vtgt : 12'h0;
    wire [31:0] acc_sum = acc_reg + {20'h0, diff_reg};
    // early release: high impedance as soon as the setpoint falls below threshold
    wire hiz_early = (st_reg == S_DN) & cfg_reg[C_HIZ][HIZ_EN_BIT]
                   & (sp_reg < cfg_reg[C_HIZ][11:0]);

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            S_FACT: begin
                // enable is not looked at here
                if (t1 >= 32'(FACT_CYCLES))
                    st_next = S_STRAP;
            end
            S_STRAP: st_next = S_DFLT;
            S_DFLT: st_next = S_USER;
            S_USER: st_next = S_READY;
            S_READY: begin
                if (en_eff)
                    st_next = S_PRE;
            end
            S_PRE: begin
                if (!en_eff)
                    st_next = S_READY;
                else if (t1 >= pre_tot)
                    st_next = S_UP;
            end
            S_UP: begin
                if (!en_eff)
                    st_next = S_SDLY;
                else if (ramp_end)
                    st_next = S_ON;
            end
            S_ON: begin
                if (!en_eff)
                    st_next = S_SDLY;
            end
            S_SDLY: begin
                if (t1 >= off_tot)
                    st_next = S_DN;
            end
            S_DN: begin
                if (hiz_early)
                    st_next = S_READY;
                else if (ramp_end)
                    st_next = S_HIZ;
            end
            S_HIZ: begin
                if (t1 >= 32'(HIZ_CYCLES))
                    st_next = S_READY;
            end
            default: st_next = S_FACT;
        endcase
        if (rst_fact)
            st_next = S_FACT;
    end

    // state and in-state timer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg <= S_FACT;
            tmr_reg <= 32'h0;
        end else begin
            st_reg <= st_next;
            tmr_reg <= (st_next != st_reg) ? 32'h0 : t1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // setpoint ramp: spreads diff unit steps evenly over ramp_tot cycles
    wire go_up = (st_reg == S_PRE) & (st_next == S_UP);
    wire go_dn = (st_reg == S_SDLY) & (st_next == S_DN);
    wire up_dir = (vtgt >= vout_sense_mv);

    always_comb begin
        sp_next = sp_reg;
        acc_next = acc_reg;
        diff_next = diff_reg;
        up_next = up_reg;
        if (go_up) begin
            // start from whatever voltage already sits on the output
            sp_next = vout_sense_mv;
            acc_next = 32'h0;
            up_next = up_dir;
            diff_next = up_dir ? vtgt - vout_sense_mv : vout_sense_mv - vtgt;
        end else if (go_dn) begin
            acc_next = 32'h0;
            up_next = 1'b0;
            diff_next = sp_reg;
        end else if (ramp_st) begin
            if (ramp_end) begin
                sp_next = ramp_tgt;
            end else if (acc_sum >= ramp_tot) begin
                acc_next = acc_sum - ramp_tot;
                sp_next = up_reg ? sp_reg + 12'h1 : sp_reg - 12'h1;
            end else begin
                acc_next = acc_sum;
            end
        end else if (st_reg == S_ON) begin
            sp_next = vtgt;
        end else if (st_reg == S_READY) begin
            sp_next = 12'h0;
        end
    end

    // ramp registers and output stage drive
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sp_reg <= 12'h0;
            acc_reg <= 32'h0;
            diff_reg <= 12'h0;
            up_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            sp_reg <= sp_next;
            acc_reg <= acc_next;
            diff_reg <= diff_next;
            up_reg <= up_next;
            drive_reg <= ((st_next & DRIVE_MASK) != 11'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pre-bias overvoltage fault; a new fault wins over a clear
    wire err_set = go_up & (vout_sense_mv > cfg_reg[C_OVP][11:0]);
    wire err_clr = wr_stat & hwdata[ST_ERR_BIT];

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            err_reg <= 1'b0;
        else
            err_reg <= err_set | (err_reg & ~err_clr);
    end

    ////////////////////////////////////////////////////////////////////////
    // power good: tolerance window, qualification delay, polarity
    wire [11:0] verr = (vout_sense_mv > vtgt) ? vout_sense_mv - vtgt
                     : vtgt - vout_sense_mv;
    wire pg_ok = (st_reg == S_ON) & ~err_reg
               & (verr <= {4'h0, cfg_reg[C_PGCFG][7:0]});
    // without its own delay enabled, power good waits one ramp time
    wire [15:0] pg_dly = cfg_reg[C_PGCFG][PG_DLYEN_BIT] ? cfg_reg[C_PGDLY]
                       : cfg_reg[C_RISE];
    wire [31:0] pg_cyc = {16'h0, pg_dly} * tick32;
    wire pg_hit = pg_ok & (pgc_reg >= pg_cyc);
    wire pg_pol = cfg_reg[C_PGCFG][PG_POL_BIT];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pgc_reg <= 32'h0;
            pg_raw_reg <= 1'b0;
            pg_out_reg <= 1'b0;
        end else begin
            // counter saturates once the delay is met
            pgc_reg <= !pg_ok ? 32'h0 : (pg_hit ? pgc_reg : pgc_reg + 32'h1);
            pg_raw_reg <= pg_hit;
            pg_out_reg <= pg_hit ^ pg_pol;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, sampled in the address phase so data is ready next cycle
    wire [3:0] rd_slot = haddr[5:2];
    wire cfg_rd = hi_zero & (haddr[7:6] == 2'h0) & (haddr[1:0] == 2'h0)
                & (rd_slot >= 4'h1) & (rd_slot <= 4'(NCFG));
    wire [3:0] rd_idx = rd_slot - 4'h1;
    wire [31:0] stat_word = {19'h0, err_reg, pg_raw_reg, st_reg};
    wire [31:0] strap_word = {12'h0, user_ok_reg, sync_reg, addr_reg, vmax_reg};
    wire [31:0] rd_word = cfg_rd ? {16'h0, cfg_reg[rd_idx]}
        : (hi_zero & haddr[7:0] == A_STATUS) ? stat_word
        : (hi_zero & haddr[7:0] == A_STRAP) ? strap_word : 32'h0;

    // zero wait states, always okay
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dph_wr_reg <= 1'b0;
            dph_map_reg <= 1'b0;
            dph_a_reg <= 8'h0;
            rdata_reg <= 32'h0;
            ready_reg <= 1'b0;
        end else begin
            dph_wr_reg <= aph & hwrite;
            dph_map_reg <= hi_zero;
            dph_a_reg <= haddr[7:0];
            rdata_reg <= (aph & ~hwrite) ? rd_word : 32'h0;
            ready_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign hrdata = rdata_reg;
    assign hreadyout = ready_reg;
    assign hresp = 1'b0;
    assign vout_set_mv = sp_reg;
    assign stage_drive = drive_reg;
    assign power_good_out = pg_out_reg;
    assign fault_flag = err_reg;
    assign smbus_addr = addr_reg;
    assign sync_sel = sync_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_layers;
        st_reg == S_DFLT ##1 st_reg == S_USER ##1 st_reg == S_READY;
    endsequence

    chk_fact_writes: assert property (
        st_fact && dph_wr_reg && dph_a_reg == A_RESTORE |=> !st_fact || tmr_reg != 0)
        else $error("bus write acted during factory load");
    chk_en_pull: assert property (
        st_reg == S_READY && module_en_float && !rst_fact |=> st_reg == S_PRE)
        else $error("floating enable not read as high");
    chk_vout_clamp: assert property (
        cfg_reg[C_VOUT] <= {4'h0, vmax_reg})
        else $error("output voltage above strap ceiling");
    chk_layer_order: assert property (
        st_reg == S_STRAP && !rst_fact |=> s_layers)
        else $error("layer load order broken");
    chk_ceiling_hold: assert property (
        !strap_smp |=> vmax_reg == $past(vmax_reg))
        else $error("ceiling changed outside strap sampling");
    chk_prebias_start: assert property (
        go_up && !rst_fact |=> sp_reg == $past(vout_sense_mv))
        else $error("ramp did not start from pre-bias");
    chk_pg_cause: assert property (
        pg_raw_reg |-> $past(st_reg) == S_ON && !$past(err_reg))
        else $error("power good without its conditions");
    chk_stop_delay: assert property (
        st_reg == S_ON && !en_eff && !rst_fact |=> st_reg == S_SDLY ##1 drive_reg)
        else $error("enable drop did not start stop delay");
    chk_hiz_off: assert property (
        st_reg == S_HIZ && st_next == S_READY |=> !stage_drive)
        else $error("stage still driven after release");
    chk_restore_fact: assert property (
        rst_fact |=> st_reg == S_FACT && tmr_reg == 0)
        else $error("factory restore did not restart sequence");

endmodule

// file: rtl/pss_pkg.sv
package pss_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int FACT_MS = 10;
    localparam int FACT_CYC = CLK_HZ / 1000 * FACT_MS;
    localparam int PRE_MS = 5;
    localparam int PRE_CYC = CLK_HZ / 1000 * PRE_MS;
    localparam int TICK_US = 10;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int HIZ_US = 100;
    localparam int HIZ_CYC = CLK_HZ / 1_000_000 * HIZ_US;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] A_RESTORE = 8'h00;
    localparam logic [7:0] A_CFG0 = 8'h04;
    localparam logic [7:0] A_STATUS = 8'h28;
    localparam logic [7:0] A_STRAP = 8'h2c;

    // configuration entries, entry i sits at A_CFG0 + 4*i
    localparam int NCFG = 9;
    localparam int C_VOUT = 0;
    localparam int C_ONDLY = 1;
    localparam int C_RISE = 2;
    localparam int C_OFFDLY = 3;
    localparam int C_FALL = 4;
    localparam int C_PGCFG = 5;
    localparam int C_PGDLY = 6;
    localparam int C_HIZ = 7;
    localparam int C_OVP = 8;

    // field positions
    localparam int R_FACT_BIT = 0;
    localparam int R_DFLT_BIT = 1;
    localparam int R_USER_BIT = 2;
    localparam int R_STORE_BIT = 3;
    localparam int PG_POL_BIT = 8;
    localparam int PG_DLYEN_BIT = 9;
    localparam int HIZ_EN_BIT = 12;
    localparam int ST_ERR_BIT = 12;

    // default layer values, also the reset values of the entries
    localparam logic [15:0] DFLT_CFG [NCFG] = '{16'h0000, 16'h0000, 16'h01f4,
        16'h0000, 16'h01f4, 16'h0032, 16'h0000, 16'h0000, 16'h0e74};

    ////////////////////////////////////////////////////////////////////////
    // output voltage strap decode in millivolts
    localparam logic [1:0] LVL_LO = 2'h0;
    localparam logic [1:0] LVL_OPEN = 2'h1;
    localparam logic [1:0] LVL_HI = 2'h2;
    localparam logic [11:0] MV_LO = 12'h258;
    localparam logic [11:0] MV_OPEN = 12'h4b0;
    localparam logic [11:0] MV_HI = 12'h9c4;
    localparam int NRES = 28;
    localparam logic [11:0] RES_MV [NRES] = '{
        12'h258, 12'h28a, 12'h2bc, 12'h2ee, 12'h320, 12'h352, 12'h384,
        12'h3b6, 12'h3e8, 12'h41a, 12'h44c, 12'h47e, 12'h4b0, 12'h4e2,
        12'h514, 12'h578, 12'h5dc, 12'h640, 12'h6a4, 12'h708, 12'h76c,
        12'h7d0, 12'h834, 12'h898, 12'h8fc, 12'h9c4, 12'hbb8, 12'hce4};
    localparam logic [15:0] VMAX_NUM = 16'h000b;
    localparam logic [15:0] VMAX_DEN = 16'h000a;

    ////////////////////////////////////////////////////////////////////////
    // sequencer states
    typedef enum logic [10:0] {
        S_FACT = 11'h001,
        S_STRAP = 11'h002,
        S_DFLT = 11'h004,
        S_USER = 11'h008,
        S_READY = 11'h010,
        S_PRE = 11'h020,
        S_UP = 11'h040,
        S_ON = 11'h080,
        S_SDLY = 11'h100,
        S_DN = 11'h200,
        S_HIZ = 11'h400
    } pss_state_t;
    localparam logic [10:0] DRIVE_MASK = 11'h7c0;

endpackage

// file: verification/pss_host_model.sv
`timescale 1ns/1ps
// host pins plus a crude plant: the output follows the setpoint while driven
module pss_host_model (
    // clock
    input wire logic clk,
    // bench requests
    input wire logic en_req,
    input wire logic float_req,
    input wire logic [11:0] prebias_mv,
    // device side
    input wire logic stage_drive,
    input wire logic [11:0] vout_set_mv,
    output logic module_en_in,
    output logic module_en_float,
    output logic [11:0] vout_sense_mv
);
    // enable moves just after an edge, like any host output
    always_ff @(posedge clk) begin
        module_en_in <= en_req;
        // a floated pin is left to the device's own pull
        module_en_float <= float_req;
    end
    // a released stage leaves whatever another source holds on the rail
    assign vout_sense_mv = stage_drive ? vout_set_mv : prebias_mv;
endmodule

// file: verification/pol_startup_ramp_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module pol_startup_ramp_sequencer_tb_top;
    import pss_pkg::*;
    logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, en_req = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, vout_strap_pin = 2'h1;
    logic [2:0] addr_strap_lo = 3'h5, addr_strap_hi = 3'h2;
    logic [4:0] vout_strap_res = 5'h1b;
    logic [11:0] prebias = 12'h0, vout_sense_mv, vout_set_mv;
    logic hreadyout, hresp, module_en_in, module_en_float, stage_drive, power_good_out;
    logic fault_flag, sync_sel;
    logic float_req = 1'b0;
    logic [5:0] smbus_addr;
    int failures = 0, comparisons = 0, cyc = 0;
    always #5 clk = ~clk;
    // short load and hold counts; the ramps keep their real length
    pss_sequencer #(.FACT_CYCLES(50), .PRE_CYCLES(20), .HIZ_CYCLES(10)) u_pss_sequencer (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .module_en_in(module_en_in), .module_en_float(module_en_float),
        .addr_strap_lo(addr_strap_lo), .addr_strap_hi(addr_strap_hi), .sync_strap(1'b1),
        .vout_strap_pin(vout_strap_pin), .vout_strap_res(vout_strap_res),
        .vout_sense_mv(vout_sense_mv), .vout_set_mv(vout_set_mv), .stage_drive(stage_drive),
        .power_good_out(power_good_out), .fault_flag(fault_flag), .smbus_addr(smbus_addr),
        .sync_sel(sync_sel));
    pss_host_model u_pss_host_model (.clk(clk), .en_req(en_req), .float_req(float_req),
        .prebias_mv(prebias),
        .stage_drive(stage_drive), .vout_set_mv(vout_set_mv), .module_en_in(module_en_in),
        .module_en_float(module_en_float), .vout_sense_mv(vout_sense_mv));
    ////////////////////////////////////////////////////////////////////////////
    // one ahb single transfer; waits on hready rather than assuming zero wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic final_report;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard, about ten percent over the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            final_report;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rchk(A_STATUS, 32'h1, "st_fact");
        // a factory restore late in the load must be dropped, or ready comes late
        repeat (40) @(posedge clk);
        xfer(1'b1, A_RESTORE, 32'h1);
        repeat (15) @(posedge clk);
        rchk(A_STATUS, 32'h10, "st_ready");
        rchk(A_CFG0, 32'h4b0, "vout_strap");
        rchk(A_STRAP, 32'h55528, "strap");
        $display("test load done");
        // straps move, but nothing is resampled until a restore
        addr_strap_lo <= 3'h0;
        vout_strap_pin <= 2'h3;
        xfer(1'b1, 8'h0c, 32'h1);
        rchk(A_STRAP, 32'h55528, "strap_hold");
        xfer(1'b1, A_RESTORE, 32'h2);
        repeat (5) @(posedge clk);
        rchk(A_STRAP, 32'h50e2e, "strap_new");
        rchk(8'h0c, 32'h1f4, "rise_dflt");
        xfer(1'b1, A_CFG0, 32'hfff);
        rchk(A_CFG0, 32'he2e, "clamp");
        xfer(1'b1, A_CFG0, 32'h3e8);
        // ramp kept above 500 us; power good stays on its default delay
        xfer(1'b1, 8'h0c, 32'h33);
        xfer(1'b1, 8'h14, 32'h1);
        xfer(1'b1, 8'h1c, 32'h1);
        // store as user layer, spoil an entry, then bring the user layer back
        xfer(1'b1, A_RESTORE, 32'h8);
        xfer(1'b1, 8'h0c, 32'h2);
        rchk(8'h0c, 32'h2, "rise_wr");
        xfer(1'b1, A_RESTORE, 32'h4);
        rchk(8'h0c, 32'h33, "rise_user");
        rchk(A_CFG0, 32'h3e8, "vout_user");
        rchk(8'h80, 32'h0, "unmapped");
        `CHK("drv_ready", 1'b0, stage_drive)
        $display("test restore done");
        // start from a pre-biased rail
        prebias <= 12'h12c;
        en_req <= 1'b1;
        repeat (15) @(posedge clk);
        `CHK("pre_wait", 1'b0, stage_drive)
        repeat (10) @(posedge clk);
        `CHK("drive_on", 1'b1, stage_drive)
        `CHK("ramp_start", 1'b1, vout_set_mv >= 12'h12c && vout_set_mv < 12'h13b)
        repeat (51000) @(posedge clk);
        rchk(A_STATUS, 32'h80, "st_on");
        `CHK("at_target", 12'h3e8, vout_set_mv)
        `CHK("pg_delay", 1'b0, power_good_out)
        // the default delay of one ramp time is far from over here
        repeat (1020) @(posedge clk);
        `CHK("pg_dflt", 1'b0, power_good_out)
        // switch to the own short delay; the count has already passed it
        xfer(1'b1, 8'h18, 32'h232);
        repeat (2) @(posedge clk);
        `CHK("pg_on", 1'b1, power_good_out)
        $display("test startup done");
        // soft stop then high impedance and back to ready
        en_req <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("pg_stop", 1'b0, power_good_out)
        repeat (1040) @(posedge clk);
        `CHK("hiz", 1'b0, stage_drive)
        rchk(A_STATUS, 32'h10, "st_back");
        $display("test stop done");
        // rail already above the overvoltage limit
        // enable pin left floating counts as enabled
        prebias <= 12'hf00;
        float_req <= 1'b1;
        repeat (30) @(posedge clk);
        `CHK("float_on", 1'b1, stage_drive)
        `CHK("ovp_fault", 1'b1, fault_flag)
        // threshold just under the starting setpoint: release long before ground
        xfer(1'b1, 8'h20, 32'h1e00);
        float_req <= 1'b0;
        repeat (600) @(posedge clk);
        `CHK("hiz_early", 1'b0, stage_drive)
        xfer(1'b1, A_STATUS, 32'h1000);
        rchk(A_STATUS, 32'h10, "fault_clr");
        xfer(1'b1, A_RESTORE, 32'h1);
        rchk(A_STATUS, 32'h1, "st_refact");
        $display("test prebias fault done");
        final_report;
    end
endmodule
